// ---- design/prot_host_regs.svh ----
// Purpose: register offsets, field positions, command bytes and timing counts
//          for the sector protection host controller
// Assumes: pclk at 250 MHz; byte-mode flash addressing
// Notes:   definitions only
`ifndef PROT_HOST_REGS_SVH
`define PROT_HOST_REGS_SVH

// clock and pin timing
`define CLK_NS         4
`define T_SETUP_NS     10
`define T_PULSE_NS     35
`define T_HOLD_NS      10
// least times round up to whole cycles
`define SETUP_CYC      ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define PULSE_CYC      ((`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC       ((`T_HOLD_NS + `CLK_NS - 1) / `CLK_NS)

// apb register offsets
`define OFF_CMD        8'h00
`define OFF_ADDR       8'h04
`define OFF_WDATA      8'h08
`define OFF_STATUS     8'h0C
`define OFF_RDATA      8'h10
`define OFF_PW_LO      8'h14
`define OFF_PW_HI      8'h18
`define OFF_PINS       8'h1C

// field positions
`define ST_BUSY        0
`define ST_DONE        1
`define ST_PROT        2
`define PINS_ACCEL     0
`define PINS_RESET_OFF 1
`define PINS_RESET     32'h0000_0002

// flash command bytes and unlock addresses
`define CMD_UNLOCK1    8'hAA
`define CMD_UNLOCK2    8'h55
`define ADR_UNLOCK1    12'hAAA
`define ADR_UNLOCK2    12'h555
`define CMD_EXIT1      8'h90
`define CMD_EXIT2      8'h00
`define CMD_RESET      8'hF0
`define CMD_PROGRAM    8'hA0
`define CMD_ERASE1     8'h80
`define CMD_ERASE2     8'h30
`define CMD_PW_START1  8'h25
`define CMD_PW_START2  8'h03
`define CMD_PW_CONFIRM 8'h29

`endif

// ---- design/prot_host_pkg.sv ----
// Purpose: types shared by the sector protection host controller
// Assumes: nothing
// Notes:   operation codes are written to the command register
package prot_host_pkg;

    // operations software can order
    typedef enum logic [3:0] {
        OP_ENTRY     = 4'h0,
        OP_EXIT      = 4'h1,
        OP_RESET     = 4'h2,
        OP_PROGRAM   = 4'h3,
        OP_ERASE_ALL = 4'h4,
        OP_READ      = 4'h5,
        OP_UNLOCK    = 4'h6
    } op_t;

    // sequencer states
    typedef enum logic [2:0] {
        SQ_IDLE  = 3'b001,
        SQ_ISSUE = 3'b010,
        SQ_WAIT  = 3'b100
    } seq_state_t;

    // single bus cycle states
    typedef enum logic [3:0] {
        CY_IDLE  = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_PULSE = 4'b0100,
        CY_HOLD  = 4'b1000
    } cyc_state_t;

endpackage

// ---- design/flash_bus_cycle.sv ----
// Purpose: one asynchronous write or read cycle on the flash pins
// Assumes: start is a one-cycle pulse while idle; inputs stable meanwhile
// Notes:   chip select falls and rises together with write strobe on writes, with output enable on reads
`timescale 1ns/100ps
`include "prot_host_regs.svh"

module flash_bus_cycle #(
    parameter int ADDR_W = 23
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              start,
    input  wire logic              is_read,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    output logic                   done,
    output logic [7:0]             rdata,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [7:0]             flash_dq_o,
    output logic                   flash_dq_oe,
    input  wire logic [7:0]        flash_dq_i,
    output logic                   flash_ce_n,
    output logic                   flash_we_n,
    output logic                   flash_oe_n
);

    prot_host_pkg::cyc_state_t state;   // phase of the cycle
    logic [7:0]                cnt;     // cycles left in phase
    logic                      rd;      // latched direction
    logic [7:0]                dq_s1;   // first sync stage
    logic [7:0]                dq_s2;   // second sync stage

    ////////////////////////////////////////////////////////////////////////
    // pin data passes two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= flash_dq_i;
            dq_s2 <= dq_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle phases; hold lasts at least two cycles so that the sync stage
    // still shows data from inside the pulse when it is captured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= prot_host_pkg::CY_IDLE;
            cnt         <= 8'h00;
            rd          <= 1'b0;
            done        <= 1'b0;
            rdata       <= 8'h00;
            flash_addr  <= '0;
            flash_dq_o  <= 8'h00;
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (state)
                prot_host_pkg::CY_IDLE: begin
                    if (start) begin
                        // address and data settle before the strobe falls
                        rd          <= is_read;
                        flash_addr  <= addr;
                        flash_dq_o  <= wdata;
                        flash_dq_oe <= ~is_read;
                        cnt         <= 8'(`SETUP_CYC - 1);
                        state       <= prot_host_pkg::CY_SETUP;
                    end
                end
                prot_host_pkg::CY_SETUP: begin
                    if (cnt == 8'h00) begin
                        flash_ce_n <= 1'b0;
                        flash_we_n <= rd;
                        flash_oe_n <= ~rd;
                        cnt        <= 8'(`PULSE_CYC - 1);
                        state      <= prot_host_pkg::CY_PULSE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                prot_host_pkg::CY_PULSE: begin
                    if (cnt == 8'h00) begin
                        // data stays driven past the rising strobe
                        flash_ce_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        cnt        <= 8'(`HOLD_CYC - 1);
                        state      <= prot_host_pkg::CY_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                prot_host_pkg::CY_HOLD: begin
                    // two edges after the rise the second stage still shows the
                    // last strobe-low sample; one edge later it shows the released bus
                    if (rd && cnt == 8'(`HOLD_CYC - 2)) begin
                        rdata <= dq_s2;
                    end
                    if (cnt == 8'h00) begin
                        flash_dq_oe <= 1'b0;
                        done        <= 1'b1;
                        state       <= prot_host_pkg::CY_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: begin
                    state <= prot_host_pkg::CY_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence strobe_low_s;
        ##1 (!flash_we_n) [*8] ##1 flash_we_n;
    endsequence

    write_pulse_a: assert property ($fell(flash_we_n) |-> strobe_low_s)
        else $error("write strobe width wrong");
    strobe_stable_a: assert property (!flash_we_n && $past(!flash_we_n)
        |-> $stable(flash_addr) && $stable(flash_dq_o))
        else $error("address or data moved under strobe");
    data_hold_a: assert property ($rose(flash_we_n) |-> flash_dq_oe)
        else $error("data released at strobe rise");
    read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("driving data during read");
    cycle_done_a: assert property (start |-> ##[14:20] done)
        else $error("bus cycle did not end in time");

endmodule // flash_bus_cycle

// ---- design/prot_host_ctrl.sv ----
// Purpose: apb-controlled host that issues sector protection command
//          sequences to a byte-mode parallel flash
// Assumes: apb master follows the usual setup then access signalling
// Notes:   one operation at a time; a new one is refused while busy
//
// Summary of operation
// - entry is AA, 55, then space selector
// - exit is 90 then 00, or F0
// - host recovers with F0 reset command
// - password byte program: A0 then byte
// - password read is eight full-address reads
// - unlock: 25, 03, eight bytes, 29
// - accel high while setting protection bits
`timescale 1ns/100ps
`include "prot_host_regs.svh"

module prot_host_ctrl #(
    parameter int ADDR_W = 23
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [7:0]             flash_dq_o,
    output logic                   flash_dq_oe,
    input  wire logic [7:0]        flash_dq_i,
    output logic                   flash_ce_n,
    output logic                   flash_we_n,
    output logic                   flash_oe_n,
    output logic                   accel_input,
    output logic                   flash_reset_n
);

    prot_host_pkg::seq_state_t state;     // sequencer state
    prot_host_pkg::op_t        op;        // operation in flight
    logic [3:0]                step;      // bus cycle within sequence
    logic [ADDR_W-1:0]         addr_reg;  // target address
    logic [7:0]                wdata_reg; // selector or value byte
    logic [63:0]               password;  // eight password bytes
    logic [7:0]                rdata_reg; // last byte read
    logic                      done_flag; // sticky completion
    logic [1:0]                pins_reg;  // accel and reset controls
    logic                      cyc_start; // pulse to cycle engine
    logic                      cyc_done;  // cycle finished
    logic [7:0]                cyc_rdata; // byte from cycle engine
    logic                      s_rd;      // this step reads
    logic                      s_last;    // this step ends the op
    logic [ADDR_W-1:0]         s_addr;    // this step's address
    logic [7:0]                s_data;    // this step's data
    logic                      busy;
    logic                      acc;
    logic                      take;
    logic                      cmd_take;
    logic                      finish;
    logic                      op_ok;

    assign busy     = (state != prot_host_pkg::SQ_IDLE);
    assign acc      = psel & penable;
    assign take     = acc & pready;
    assign op_ok    = (pwdata[3:0] <= 4'h6);
    assign cmd_take = take & pwrite & (paddr == `OFF_CMD) & ~busy & op_ok;
    assign finish   = (state == prot_host_pkg::SQ_WAIT) & cyc_done & s_last;

    ////////////////////////////////////////////////////////////////////////
    // step table: address, data and direction of each bus cycle
    always_comb begin
        s_rd   = 1'b0;
        s_last = 1'b0;
        s_addr = '0;
        s_data = 8'h00;
        unique case (op)
            prot_host_pkg::OP_ENTRY: begin
                // unlock pair then the space selector
                s_last = (step == 4'd2);
                s_addr = ADDR_W'((step == 4'd1) ? `ADR_UNLOCK2 : `ADR_UNLOCK1);
                s_data = (step == 4'd0) ? `CMD_UNLOCK1 :
                         (step == 4'd1) ? `CMD_UNLOCK2 : wdata_reg;
            end
            prot_host_pkg::OP_EXIT: begin
                s_last = (step == 4'd1);
                s_data = (step == 4'd0) ? `CMD_EXIT1 : `CMD_EXIT2;
            end
            prot_host_pkg::OP_RESET: begin
                // also the way out after any malformed sequence
                s_last = 1'b1;
                s_data = `CMD_RESET;
            end
            prot_host_pkg::OP_PROGRAM: begin
                // password byte, lock register, bit set or clear, freeze
                s_last = (step == 4'd1);
                s_addr = (step == 4'd1) ? addr_reg : '0;
                s_data = (step == 4'd1) ? wdata_reg : `CMD_PROGRAM;
            end
            prot_host_pkg::OP_ERASE_ALL: begin
                s_last = (step == 4'd1);
                s_data = (step == 4'd0) ? `CMD_ERASE1 : `CMD_ERASE2;
            end
            prot_host_pkg::OP_READ: begin
                // full address driven; password, lock or status read
                s_rd   = 1'b1;
                s_last = 1'b1;
                s_addr = addr_reg;
            end
            prot_host_pkg::OP_UNLOCK: begin
                // bytes go in offset order, which the device also accepts
                s_last = (step == 4'd10);
                if (step >= 4'd2 && step <= 4'd9) begin
                    s_addr = ADDR_W'(step - 4'd2);
                    s_data = password[8*(step-4'd2) +: 8];
                end else begin
                    s_data = (step == 4'd0) ? `CMD_PW_START1 :
                             (step == 4'd1) ? `CMD_PW_START2 : `CMD_PW_CONFIRM;
                end
            end
            default: begin
                s_last = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: issue one cycle per step until the last one finishes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= prot_host_pkg::SQ_IDLE;
            op        <= prot_host_pkg::OP_RESET;
            step      <= 4'h0;
            cyc_start <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            cyc_start <= 1'b0;
            unique case (state)
                prot_host_pkg::SQ_IDLE: begin
                    if (cmd_take) begin
                        op    <= prot_host_pkg::op_t'(pwdata[3:0]);
                        step  <= 4'h0;
                        state <= prot_host_pkg::SQ_ISSUE;
                    end
                end
                prot_host_pkg::SQ_ISSUE: begin
                    cyc_start <= 1'b1;
                    state     <= prot_host_pkg::SQ_WAIT;
                end
                prot_host_pkg::SQ_WAIT: begin
                    if (cyc_done) begin
                        if (s_rd) begin
                            rdata_reg <= cyc_rdata;
                        end
                        if (s_last) begin
                            state <= prot_host_pkg::SQ_IDLE;
                        end else begin
                            step  <= step + 4'h1;
                            state <= prot_host_pkg::SQ_ISSUE;
                        end
                    end
                end
                default: begin
                    state <= prot_host_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, read data and error set up beforehand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc & ~pready;
            if (acc & ~pready) begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
                unique case (paddr)
                    `OFF_CMD: begin
                        // refuse while busy or for an unknown code
                        pslverr <= pwrite & (busy | ~op_ok);
                        prdata  <= {28'h000_0000, op};
                    end
                    `OFF_ADDR:   prdata <= 32'(addr_reg);
                    `OFF_WDATA:  prdata <= {24'h00_0000, wdata_reg};
                    `OFF_STATUS: begin
                        // protected shows when the read byte has bit 0 low
                        prdata[`ST_BUSY] <= busy;
                        prdata[`ST_DONE] <= done_flag;
                        prdata[`ST_PROT] <= ~rdata_reg[0];
                    end
                    `OFF_RDATA:  prdata <= {24'h00_0000, rdata_reg};
                    `OFF_PW_LO:  prdata <= password[31:0];
                    `OFF_PW_HI:  prdata <= password[63:32];
                    `OFF_PINS:   prdata <= {30'h0000_0000, pins_reg};
                    default:     pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers written at the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg  <= '0;
            wdata_reg <= 8'h00;
            password  <= 64'h0000_0000_0000_0000;
            pins_reg  <= 2'(`PINS_RESET);
        end else if (take & pwrite) begin
            unique case (paddr)
                `OFF_ADDR:  addr_reg       <= pwdata[ADDR_W-1:0];
                `OFF_WDATA: wdata_reg      <= pwdata[7:0];
                `OFF_PW_LO: password[31:0] <= pwdata;
                `OFF_PW_HI: password[63:32] <= pwdata;
                `OFF_PINS:  pins_reg       <= pwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion flag: a finish in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (finish) begin
            done_flag <= 1'b1;
        end else if (take & pwrite & (paddr == `OFF_STATUS) & pwdata[`ST_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accel is raised automatically for bit programming and erase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accel_input   <= 1'b0;
            flash_reset_n <= 1'b0;
        end else begin
            accel_input   <= pins_reg[`PINS_ACCEL] | (busy &
                             (op == prot_host_pkg::OP_PROGRAM ||
                              op == prot_host_pkg::OP_ERASE_ALL));
            flash_reset_n <= pins_reg[`PINS_RESET_OFF];
        end
    end

    flash_bus_cycle #(.ADDR_W(ADDR_W)) cycle_engine (
        .pclk        (pclk),
        .presetn     (presetn),
        .start       (cyc_start),
        .is_read     (s_rd),
        .addr        (s_addr),
        .wdata       (s_data),
        .done        (cyc_done),
        .rdata       (cyc_rdata),
        .flash_addr  (flash_addr),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe),
        .flash_dq_i  (flash_dq_i),
        .flash_ce_n  (flash_ce_n),
        .flash_we_n  (flash_we_n),
        .flash_oe_n  (flash_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks; helper counts cycles issued in the current operation
    logic [4:0] n_start;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_start <= 5'h00;
        end else if (cmd_take) begin
            n_start <= 5'h00;
        end else if (cyc_start) begin
            n_start <= n_start + 5'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (acc && !pready |=> pready && $stable(paddr))
        else $error("apb answer not one wait state");
    first_cycle_a: assert property (cmd_take |-> ##2 cyc_start)
        else $error("first bus cycle late");
    entry_count_a: assert property (finish && op == prot_host_pkg::OP_ENTRY
        |-> n_start == 5'd3)
        else $error("entry sequence length wrong");
    exit_count_a: assert property (finish && op == prot_host_pkg::OP_EXIT
        |-> n_start == 5'd2)
        else $error("exit sequence length wrong");
    unlock_count_a: assert property (finish && op == prot_host_pkg::OP_UNLOCK
        |-> n_start == 5'd11)
        else $error("unlock sequence length wrong");
    done_flag_a: assert property (finish |=> done_flag && !busy)
        else $error("completion not flagged");
    accel_high_a: assert property (busy && op == prot_host_pkg::OP_PROGRAM
        ##1 busy |-> accel_input)
        else $error("accel low while programming bits");
    read_capture_a: assert property (finish && s_rd |=> rdata_reg == $past(cyc_rdata))
        else $error("read byte not kept");

endmodule // prot_host_ctrl

// ---- test/flash_prot_model.sv ----
// Purpose: byte-mode flash seen only through its protection command spaces
// Assumes: writes strobe with chip select and write strobe both low
// Notes:   every write made while flash_reset_n is high is logged as {accel, address, data}
`timescale 1ns/100ps
module flash_prot_model (
    input  wire logic [22:0] flash_addr,
    input  wire logic [7:0]  flash_dq_i,
    output logic      [7:0]  dq_m,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n,
    input  wire logic        accel_input,
    input  wire logic        flash_reset_n
);
    logic [22:0] la;                                // latched target address
    logic [7:0]  sp = 8'h00;                        // open command space, 0 = array
    logic [7:0]  v;                                 // value offered on a read
    logic [31:0] wlog[$];                           // every write seen while flash_reset_n is high
    logic [63:0] pw = 64'h8877_6655_4433_2211;      // stored password
    wire         stb_n = flash_ce_n | flash_we_n;   // strobe low only when both low
    ////////////////////////////////////////////////////////////////////////
    // address at the later fall, data at the earlier rise of the two strobes
    always @(negedge stb_n or negedge flash_oe_n) la = flash_addr;
    always @(posedge stb_n) begin
        if (flash_reset_n === 1'b1) begin
            wlog.push_back({accel_input, la, flash_dq_i});
            // exit by F0, or 90 then 00
            if (flash_dq_i == 8'hF0 || (flash_dq_i == 8'h00 && wlog[$-1][7:0] == 8'h90))
                sp = 8'h00;
            else if (wlog.size() > 2 && wlog[$-2][7:0] == 8'hAA && wlog[$-1][7:0] == 8'h55)
                sp = flash_dq_i;
        end
    end
    // reads; a released bus shows the inverse so stale data never matches
    always_comb begin
        case (sp)
            8'h60:               v = pw[la[2:0]*8 +: 8]; // any order, low bits only
            8'hC0, 8'hE0, 8'h50: v = 8'hFE; // all protected, dq0 low
            default:             v = flash_addr[7:0] ^ 8'h5A; // plain array data
        endcase
    end
    assign dq_m = (flash_ce_n | flash_oe_n) ? ~v : v;
endmodule // flash_prot_model

// ---- test/prot_host_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the protection host controller
// Assumes: model answers reads at once
// Notes:   flash traffic is judged from the model's write log
`timescale 1ns/100ps
`include "prot_host_regs.svh"
module prot_host_ctrl_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [7:0]  paddr = 0, flash_dq_o, flash_dq_i, dq_m;
    logic [31:0] pwdata = 0, prdata, r;
    logic [22:0] flash_addr;
    logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, accel_input, flash_reset_n;
    int fails = 0, checked = 0, cyc = 0;
    logic [7:0] sels[5] = '{8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0}; // every space selector
    assign flash_dq_i = flash_dq_oe ? flash_dq_o : dq_m; // resolved data wire
    always #2 pclk = ~pclk;
    prot_host_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
        .flash_ce_n, .flash_we_n, .flash_oe_n, .accel_input, .flash_reset_n);
    flash_prot_model i_model (.flash_addr, .flash_dq_i, .dq_m, .flash_ce_n, .flash_we_n,
        .flash_oe_n, .accel_input, .flash_reset_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // start an operation and wait for done, then clear done
    task automatic op(input prot_host_pkg::op_t c);
        apb(1, `OFF_CMD, {28'h0, c});
        do apb(0, `OFF_STATUS, 0); while (r[`ST_DONE] !== 1'b1 || r[`ST_BUSY] !== 1'b0);
        apb(1, `OFF_STATUS, 32'h0000_0002);
    endtask
    function automatic logic [31:0] lg(int k);
        return i_model.wlog[i_model.wlog.size() - k];
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic t_spaces;
        foreach (sels[i]) begin
            apb(1, `OFF_WDATA, {24'h0, sels[i]});
            op(prot_host_pkg::OP_ENTRY);
            chk("entry1", lg(3), {1'b0, 23'hAAA, 8'hAA});
            chk("entry2", lg(2), {1'b0, 23'h555, 8'h55});
            chk("entry3", lg(1), {1'b0, 23'hAAA, sels[i]});
            op(prot_host_pkg::OP_EXIT);
            chk("exit1", lg(2), {1'b0, 23'h0, 8'h90});
            chk("exit2", lg(1), {1'b0, 23'h0, 8'h00});
        end
        $display("spaces test done");
    endtask
    task automatic t_password;
        apb(1, `OFF_PW_LO, 32'h4433_2211);
        apb(1, `OFF_PW_HI, 32'h8877_6655);
        apb(1, `OFF_WDATA, 32'h0000_0060);
        op(prot_host_pkg::OP_ENTRY);
        for (int k = 7; k >= 0; k--) begin
            apb(1, `OFF_ADDR, k);
            op(prot_host_pkg::OP_READ);
            apb(0, `OFF_RDATA, 0);
            chk("pw read", r[7:0], 8'h11 * (k + 1));
        end
        apb(1, `OFF_ADDR, 32'h0000_0003);
        apb(1, `OFF_WDATA, 32'h0000_0044);
        op(prot_host_pkg::OP_PROGRAM);
        chk("pw prog a", lg(2), {1'b1, 23'h0, 8'hA0});
        chk("pw prog b", lg(1), {1'b1, 23'h3, 8'h44});
        op(prot_host_pkg::OP_UNLOCK);
        chk("unlock a", lg(11), {1'b0, 23'h0, 8'h25});
        chk("unlock b", lg(10), {1'b0, 23'h0, 8'h03});
        for (int k = 0; k < 8; k++) begin
            chk("unlock pw", lg(9 - k), {1'b0, 23'(k), 8'(8'h11 * (k + 1))});
        end
        chk("unlock c", lg(1), {1'b0, 23'h0, 8'h29});
        op(prot_host_pkg::OP_RESET);
        chk("reset", lg(1), {1'b0, 23'h0, 8'hF0});
        $display("password test done");
    endtask
    task automatic t_protect;
        apb(1, `OFF_WDATA, 32'h0000_00C0);
        op(prot_host_pkg::OP_ENTRY);
        apb(1, `OFF_ADDR, 32'h0030_8000);
        apb(1, `OFF_WDATA, 0);
        op(prot_host_pkg::OP_PROGRAM);
        chk("bit prog", lg(1), {1'b1, 23'h30_8000, 8'h00});
        op(prot_host_pkg::OP_ERASE_ALL);
        chk("erase a", lg(2), {1'b1, 23'h0, 8'h80});
        chk("erase b", lg(1), {1'b1, 23'h0, 8'h30});
        op(prot_host_pkg::OP_READ);
        apb(0, `OFF_STATUS, 0);
        chk("protected", r[`ST_PROT], 1'b1);
        apb(1, `OFF_CMD, 32'h0000_0007);
        chk("bad op", e, 1'b1);
        apb(0, 8'h20, 0);
        chk("unmapped", {e, r}, {1'b1, 32'h0});
        $display("protect test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_of_test;
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_spaces;
        t_password;
        t_protect;
        end_of_test;
    end
endmodule // prot_host_ctrl_tb_top
